/* File: rtl/burst_write_byte_mask.v */
// burst sram core: port selects, 4-beat bursts, byte-lane write masking
`timescale 1ns/1ps
`include "burst_write_byte_mask_map.vh"

// Functional notes
// - 8-bit variant: lane 0 gates bits 3:0, lane 1 gates 7:4.
// - 18-bit variant: lane 0 gates bits 8:0, lane 1 gates 17:9.
// - 36-bit variant: four lanes gate 8:0, 17:9, 26:18, 35:27.
// - a lane select low during a data beat writes that lane.
// - a lane select high keeps the stored lane contents unchanged.
// - all lane selects high means that beat writes nothing.
// - lane selects are sampled per beat on both input edges; may change.
// - powers up with both ports deselected and read outputs undriven.
// - each burst touches the latched address and the next three locations.
// - write data on both input ref rises; read data on output ref rises, or on input ref rises in single clock mode.
// - same-type starts on consecutive input ref rises: second is ignored.
// - a port select that started an op is ignored the next rise.
// - write starts on select low; four words follow over two cycles.
module burst_write_byte_mask #(
	parameter DATA_W = 18,
	parameter ADDR_W = 8
) (
	input wire MCLK, // system clock, 40 MHz
	input wire RESET, // asynchronous reset, active high
	input wire INPUT_TIMING_REF, // input_timing_ref
	input wire INPUT_TIMING_REF_INVERTED, // input_timing_ref_inverted
	input wire OUTPUT_TIMING_REF, // output_timing_ref
	input wire OUTPUT_TIMING_REF_INVERTED, // output_timing_ref_inverted
	input wire [ADDR_W-1:0] ADDR, // burst base address
	input wire READ_PORT_SELECT_N, // read_port_select, active low
	input wire WRITE_PORT_SELECT_N, // write_port_select, active low
	input wire [3:0] BYTE_LANE_WRITE_SELECT_N, // byte_lane_write_select, active low
	input wire [DATA_W-1:0] DATA_IN, // write data
	output reg [DATA_W-1:0] DATA_OUT, // read data
	output reg DATA_OUT_EN // read data drive enable
);

localparam LANE_W = (DATA_W == `NARROW_DATA_W) ? `NIBBLE_LANE_W : `BYTE9_LANE_W;
localparam SW = 4 + ADDR_W + 2 + 4 + DATA_W;

//--------------------------------
// helpers
//--------------------------------
function [ADDR_W-1:0] burst_addr;
	input [ADDR_W-1:0] base;
	input [1:0] beat;
	begin
		burst_addr = base + {{(ADDR_W-2){1'b0}}, beat};
	end
endfunction

//--------------------------------
// pin synchronisers
//--------------------------------
reg [SW-1:0] sync1_reg;
reg [SW-1:0] sync2_reg;
reg [3:0] clk_dly_reg;
wire [SW-1:0] pins;
assign pins = {INPUT_TIMING_REF, INPUT_TIMING_REF_INVERTED, OUTPUT_TIMING_REF,
	OUTPUT_TIMING_REF_INVERTED, ADDR, READ_PORT_SELECT_N, WRITE_PORT_SELECT_N,
	BYTE_LANE_WRITE_SELECT_N, DATA_IN};

always @(posedge MCLK or posedge RESET) begin
	if (RESET) begin
		sync1_reg <= {SW{1'b1}};
		sync2_reg <= {SW{1'b1}};
		clk_dly_reg <= 4'hF;
	end else begin
		sync1_reg <= pins;
		sync2_reg <= sync1_reg;
		clk_dly_reg <= sync2_reg[SW-1:SW-4];
	end
end

wire [3:0] clk_s = sync2_reg[SW-1:SW-4];
wire [ADDR_W-1:0] addr_s = sync2_reg[SW-5 -: ADDR_W];
wire rd_sel_n_s = sync2_reg[DATA_W+4+1];
wire wr_sel_n_s = sync2_reg[DATA_W+4];
wire [3:0] lane_n_s = sync2_reg[DATA_W+3:DATA_W];
wire [DATA_W-1:0] data_s = sync2_reg[DATA_W-1:0];

wire [3:0] rise = clk_s & ~clk_dly_reg;
wire in_rise = rise[3];
wire in_inv_rise = rise[2];

//--------------------------------
// single clock strap
//--------------------------------
reg [1:0] strap_cnt_reg;
reg single_reg;
always @(posedge MCLK or posedge RESET) begin
	if (RESET) begin
		strap_cnt_reg <= 2'h0;
		single_reg <= 1'b0;
	end else if (strap_cnt_reg != `STRAP_SAMPLE_CNT) begin
		strap_cnt_reg <= strap_cnt_reg + 2'h1;
		if (strap_cnt_reg + 2'h1 == `STRAP_SAMPLE_CNT) begin
			single_reg <= clk_s[1] & clk_s[0];
		end
	end
end
wire strap_ok = (strap_cnt_reg == `STRAP_SAMPLE_CNT);

// output edges from C pair, or K pair in single mode
wire o_rise = strap_ok & (single_reg ? rise[3] : rise[1]);
wire on_rise = strap_ok & (single_reg ? rise[2] : rise[0]);

//--------------------------------
// port select arbitration
//--------------------------------
reg [1:0] last_op_reg;
wire rd_ok = ~rd_sel_n_s & (last_op_reg != `OP_READ);
wire wr_ok = ~wr_sel_n_s & (last_op_reg != `OP_WRITE);
wire start_rd = in_rise & rd_ok;
wire start_wr = in_rise & wr_ok & ~rd_ok;

always @(posedge MCLK or posedge RESET) begin
	if (RESET) begin
		last_op_reg <= `OP_NONE;
	end else if (in_rise) begin
		last_op_reg <= start_rd ? `OP_READ : (start_wr ? `OP_WRITE : `OP_NONE);
	end
end

//--------------------------------
// write burst
//--------------------------------
reg wr_pend_reg;
reg [ADDR_W-1:0] wr_pend_addr_reg;
reg wr_active_reg;
reg [1:0] wr_beat_reg;
reg [ADDR_W-1:0] wr_base_reg;

// four beats on in, inverted, in, inverted rises after start
// data taken on both input ref rises
wire wr_in_beat = in_rise & (wr_pend_reg | (wr_active_reg & (wr_beat_reg == `BEAT_2)));
wire wr_inv_beat = in_inv_rise & wr_active_reg &
	((wr_beat_reg == `BEAT_1) | (wr_beat_reg == `BEAT_3));
wire [1:0] wr_beat_now = (in_rise & wr_pend_reg) ? `BEAT_0 : wr_beat_reg;
wire [ADDR_W-1:0] wr_base_now = (in_rise & wr_pend_reg) ? wr_pend_addr_reg : wr_base_reg;

always @(posedge MCLK or posedge RESET) begin
	if (RESET) begin
		wr_pend_reg <= 1'b0;
		wr_pend_addr_reg <= {ADDR_W{1'b0}};
		wr_active_reg <= 1'b0;
		wr_beat_reg <= `BEAT_0;
		wr_base_reg <= {ADDR_W{1'b0}};
	end else begin
		if (in_rise) begin
			wr_pend_reg <= start_wr;
			if (start_wr) begin
				wr_pend_addr_reg <= addr_s;
			end
		end
		if (wr_in_beat) begin
			wr_active_reg <= 1'b1;
			wr_base_reg <= wr_base_now;
			wr_beat_reg <= wr_beat_now + 2'h1;
		end else if (wr_inv_beat) begin
			wr_beat_reg <= wr_beat_reg + 2'h1;
			if (wr_beat_reg == `BEAT_3) begin
				wr_active_reg <= 1'b0;
			end
		end
	end
end

//--------------------------------
// byte-lane masking
//--------------------------------
wire [DATA_W-1:0] bit_mask;
genvar gi;
generate
	for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_mask
		// nibble lanes for the 8-bit variant
		// 9-bit lanes for the 18-bit variant
		// four 9-bit lanes for the 36-bit variant
		assign bit_mask[gi] = ~lane_n_s[gi / LANE_W];
	end
endgenerate

// no lane enabled means no write
wire mem_we = (wr_in_beat | wr_inv_beat) & (|bit_mask);

//--------------------------------
// read burst
//--------------------------------
reg rd_pend_reg;
reg [ADDR_W-1:0] rd_pend_addr_reg;
reg rd_armed_reg;
reg [ADDR_W-1:0] rd_armed_addr_reg;
reg rd_active_reg;
reg [1:0] rd_beat_reg;
reg [ADDR_W-1:0] rd_base_reg;

wire rd_first = on_rise & rd_armed_reg;
wire rd_launch = rd_first |
	(on_rise & rd_active_reg & (rd_beat_reg == `BEAT_2)) |
	(o_rise & rd_active_reg & ((rd_beat_reg == `BEAT_1) | (rd_beat_reg == `BEAT_3)));
wire [ADDR_W-1:0] rd_addr;
wire [DATA_W-1:0] rd_data;
assign rd_addr = rd_first ? burst_addr(rd_armed_addr_reg, `BEAT_0) :
	burst_addr(rd_base_reg, rd_beat_reg);

always @(posedge MCLK or posedge RESET) begin
	if (RESET) begin
		rd_pend_reg <= 1'b0;
		rd_pend_addr_reg <= {ADDR_W{1'b0}};
		rd_armed_reg <= 1'b0;
		rd_armed_addr_reg <= {ADDR_W{1'b0}};
		rd_active_reg <= 1'b0;
		rd_beat_reg <= `BEAT_0;
		rd_base_reg <= {ADDR_W{1'b0}};
		DATA_OUT <= {DATA_W{`RESET_DATA}};
		DATA_OUT_EN <= `RESET_OE;
	end else begin
		if (start_rd) begin
			rd_pend_reg <= 1'b1;
			rd_pend_addr_reg <= addr_s;
		end else if (o_rise) begin
			rd_pend_reg <= 1'b0;
		end
		// first output rise after start is the wait
		if (o_rise & rd_pend_reg) begin
			rd_armed_reg <= 1'b1;
			rd_armed_addr_reg <= rd_pend_addr_reg;
		end else if (rd_first) begin
			rd_armed_reg <= 1'b0;
		end
		if (rd_first) begin
			rd_active_reg <= 1'b1;
			rd_base_reg <= rd_armed_addr_reg;
			rd_beat_reg <= `BEAT_1;
		end else if (rd_launch) begin
			rd_beat_reg <= rd_beat_reg + 2'h1;
			if (rd_beat_reg == `BEAT_3) begin
				rd_active_reg <= 1'b0;
			end
		end
		// read data launched on output ref rises, or on input ref rises in single mode
		// outputs released when no beat is due
		if (rd_launch) begin
			DATA_OUT <= rd_data;
			DATA_OUT_EN <= 1'b1;
		end else if (o_rise | on_rise) begin
			DATA_OUT_EN <= 1'b0;
		end
	end
end

//--------------------------------
// storage
//--------------------------------
// masked-off lanes keep old contents
// write beats walk A to A+3
burst_sram_array #(
	.DW(DATA_W),
	.AW(ADDR_W)
) u_array (
	.clk(MCLK),
	.we(mem_we),
	.waddr(burst_addr(wr_base_now, wr_beat_now)),
	.wdata(data_s),
	.wmask(bit_mask),
	.raddr(rd_addr),
	.rdata(rd_data)
);

endmodule

/* File: rtl/burst_write_byte_mask_map.vh */
// constants for the burst sram write port with byte-lane masking
`ifndef BURST_WRITE_BYTE_MASK_MAP_VH
`define BURST_WRITE_BYTE_MASK_MAP_VH

// lane widths per variant
`define NARROW_DATA_W 8
`define NIBBLE_LANE_W 4
`define BYTE9_LANE_W 9
`define MAX_LANES 4

// last operation started on the input timing ref
`define OP_NONE 2'h0
`define OP_READ 2'h1
`define OP_WRITE 2'h2

// burst beat numbers
`define BEAT_0 2'h0
`define BEAT_1 2'h1
`define BEAT_2 2'h2
`define BEAT_3 2'h3

// synchroniser depth, strap sample count and reset values
`define SYNC_STAGES 2
`define STRAP_SAMPLE_CNT 2'h3
`define RESET_DATA 1'b0
`define RESET_OE 1'b0

`endif

/* File: rtl/burst_sram_array.v */
// storage array with per-bit write mask and asynchronous read
`timescale 1ns/1ps
module burst_sram_array #(
	parameter DW = 18,
	parameter AW = 8
) (
	input wire clk, // array clock
	input wire we, // write one word
	input wire [AW-1:0] waddr, // write word address
	input wire [DW-1:0] wdata, // write data
	input wire [DW-1:0] wmask, // 1 = bit is written
	input wire [AW-1:0] raddr, // read word address
	output wire [DW-1:0] rdata // read data
);

reg [DW-1:0] mem [0:(1<<AW)-1];

//--------------------------------
// masked write
//--------------------------------
always @(posedge clk) begin
	if (we) begin
		mem[waddr] <= (wdata & wmask) | (mem[waddr] & ~wmask);
	end
end

assign rdata = mem[raddr];

endmodule

/* File: bench/timing_ref_source.sv */
// controller-side timing clock source
`timescale 1ns/1ps
module timing_ref_source (
	input wire mclk, // system clock
	input wire reset, // active high
	input wire run, // low stops clocks
	output wire in_ref, // input ref
	output wire in_ref_inv, // inverted input ref
	output wire out_ref, // output ref
	output wire out_ref_inv // inverted output ref
);
	reg [3:0] cnt_reg;
	always @(posedge mclk or posedge reset) begin
		if (reset)
			cnt_reg <= 4'h0;
		else
			cnt_reg <= cnt_reg + 4'h1;
	end
	assign in_ref = ~run | ~cnt_reg[3];
	assign in_ref_inv = ~run | cnt_reg[3];
	assign out_ref = in_ref;
	assign out_ref_inv = in_ref_inv;
endmodule

/* File: bench/burst_write_byte_mask_asserts.sv */
// pin-level checks of the burst sram read port
`timescale 1ns/1ps
module burst_write_byte_mask_checker #(
	parameter DATA_W = 18
) (
	input wire MCLK, // clock
	input wire RESET, // reset
	input wire INPUT_TIMING_REF, // input ref
	input wire INPUT_TIMING_REF_INVERTED, // input ref inverted
	input wire OUTPUT_TIMING_REF, // output ref
	input wire OUTPUT_TIMING_REF_INVERTED, // output ref inverted
	input wire READ_PORT_SELECT_N, // read select
	input wire WRITE_PORT_SELECT_N, // write select
	input wire [DATA_W-1:0] DATA_OUT, // read data
	input wire DATA_OUT_EN // drive enable
);
	localparam int MAX_AGE = 200;
	reg [3:0] pins_reg;
	reg [1:0] last_reg;
	reg ever_reg;
	reg [9:0] age_reg;
	wire [3:0] pins = {INPUT_TIMING_REF, INPUT_TIMING_REF_INVERTED, OUTPUT_TIMING_REF,
		OUTPUT_TIMING_REF_INVERTED};
	wire in_rise = INPUT_TIMING_REF & ~pins_reg[3];
	wire orise = |(pins & ~pins_reg);
	wire rd_take = in_rise & ~READ_PORT_SELECT_N & (last_reg != 2'h1);
	wire wr_take = in_rise & ~WRITE_PORT_SELECT_N & (last_reg != 2'h2) & ~rd_take;
	always @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			pins_reg <= 4'hF;
			last_reg <= 2'h0;
			ever_reg <= 1'b0;
			age_reg <= 10'h3FF;
		end else begin
			pins_reg <= pins;
			if (in_rise)
				last_reg <= rd_take ? 2'h1 : (wr_take ? 2'h2 : 2'h0);
			if (rd_take)
				ever_reg <= 1'b1;
			age_reg <= rd_take ? 10'h000 : age_reg + {9'h000, age_reg != 10'h3FF};
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	a_reset_quiet: assert property (disable iff (1'b0) RESET |-> !DATA_OUT_EN && DATA_OUT == '0)
		else $error("output active in reset");
	a_idle_no_en: assert property (!ever_reg |-> !DATA_OUT_EN)
		else $error("output enabled before any read");
	a_idle_no_data: assert property (!ever_reg |-> DATA_OUT == '0)
		else $error("read data moved before any read");
	a_out_on_edge: assert property ($changed(DATA_OUT) |-> $past(orise, 2) || $past(orise, 3) || $past(orise, 4))
		else $error("read data changed off an output edge");
	a_en_fall_edge: assert property ($fell(DATA_OUT_EN) |-> $past(orise, 2) || $past(orise, 3) || $past(orise, 4))
		else $error("enable dropped off an output edge");
	a_read_answer: assert property (rd_take |-> ##[2:300] DATA_OUT_EN)
		else $error("accepted read gave no data");
	a_rose_after_read: assert property ($rose(DATA_OUT_EN) |-> age_reg >= 3 && age_reg <= MAX_AGE)
		else $error("enable rose without a recent read");
	a_burst_span: assert property (DATA_OUT_EN |-> age_reg < MAX_AGE)
		else $error("enable outlived its burst");
endmodule

/* File: bench/test_burst_write_byte_mask.sv */
// self-checking bench: three width variants against a lane-masked memory model
`timescale 1ns/1ps
module test_burst_write_byte_mask;
	localparam int NS = 44;
	logic mclk = 1'b0;
	logic reset = 1'b0;
	logic run = 1'b1;
	logic rd_sel_n = 1'b1;
	logic wr_sel_n = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [3:0] bw_n = 4'hF;
	logic [35:0] din = 36'h0;
	wire in_ref, in_ref_inv, out_ref, out_ref_inv;
	wire [35:0] q [3];
	wire [2:0] en;
	logic [1:0] sel [NS];
	logic [7:0] ad [NS];
	logic [35:0] dn [NS], dk [NS], mem [3][256], eq [3][NS][2];
	logic [3:0] bn [NS], bk [NS];
	bit ee [NS][2];
	int failures = 0;
	int n_checks = 0;
	always #12.5 mclk = ~mclk;
	timing_ref_source i_timing_ref_source (.mclk(mclk), .reset(reset), .run(run),
		.in_ref(in_ref), .in_ref_inv(in_ref_inv), .out_ref(out_ref),
		.out_ref_inv(out_ref_inv));
	for (genvar g = 0; g < 3; g++) begin : g_v
		localparam int W = g == 0 ? 8 : (g == 1 ? 18 : 36);
		burst_write_byte_mask #(.DATA_W(W), .ADDR_W(8)) i_burst_write_byte_mask (
			.MCLK(mclk), .RESET(reset), .INPUT_TIMING_REF(in_ref),
			.INPUT_TIMING_REF_INVERTED(in_ref_inv), .OUTPUT_TIMING_REF(out_ref),
			.OUTPUT_TIMING_REF_INVERTED(out_ref_inv), .ADDR(addr),
			.READ_PORT_SELECT_N(rd_sel_n), .WRITE_PORT_SELECT_N(wr_sel_n),
			.BYTE_LANE_WRITE_SELECT_N(bw_n), .DATA_IN(din[W-1:0]),
			.DATA_OUT(q[g][W-1:0]), .DATA_OUT_EN(en[g]));
	end
	function automatic logic [35:0] lm(int v, logic [3:0] b);
		int w;
		w = v == 0 ? 4 : 9;
		lm = 36'h0;
		for (int i = 0; i < (v == 2 ? 4 : 2); i++)
			if (!b[i]) lm = lm | (((36'h1 << w) - 36'h1) << (i * w));
	endfunction
	task automatic chk(string nm, logic [35:0] e, logic [35:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(int i, logic [7:0] a, bit ign, int bm);
		logic [35:0] d;
		logic [3:0] b;
		int s;
		sel[i][0] = 1'b0;
		ad[i] = a;
		for (int n = 0; n < 4; n++) begin
			d = 36'({$urandom, $urandom});
			b = bm < 0 ? 4'($urandom) : 4'(bm);
			s = i + 1 + (n + 1) / 2;
			if (n % 2)
				{dn[s], bn[s]} = {d, b};
			else
				{dk[s], bk[s]} = {d, b};
			for (int v = 0; v < 3; v++)
				if (!ign) mem[v][8'(a + n)] = mem[v][8'(a + n)] & ~lm(v, b) | d & lm(v, b);
		end
	endtask
	task automatic rd(int j, logic [7:0] a);
		int s;
		sel[j][1] = 1'b0;
		ad[j] = a;
		for (int n = 0; n < 4; n++) begin
			s = j + 2 + (n + 1) / 2;
			ee[s][1 - n % 2] = 1'b1;
			for (int v = 0; v < 3; v++)
				eq[v][s][1 - n % 2] = mem[v][8'(a + n)] & lm(v, 4'h0);
		end
	endtask
	initial begin
		void'($urandom(99959));
		// reset edge after time zero so the asynchronous reset branches really run
		#5 reset = 1'b1;
		for (int s = 0; s < NS; s++) begin
			sel[s] = 2'b11;
			ad[s] = 8'h00;
			{bn[s], bk[s]} = 8'hFF;
			{dn[s], dk[s]} = 72'h0;
		end
		wr(2, 8'hFE, 0, 0);
		wr(4, 8'h10, 0, 0);
		wr(6, 8'h40, 0, 0);
		wr(8, 8'hFE, 0, -1);
		wr(10, 8'h10, 0, -1);
		wr(12, 8'h40, 0, 15);
		wr(14, 8'h80, 0, 0);
		wr(17, 8'h80, 1, 0);
		wr(16, 8'h12, 0, 0);
		rd(22, 8'hFE);
		rd(24, 8'h10);
		rd(26, 8'h40);
		rd(28, 8'h12);
		rd(30, 8'h80);
		rd(32, 8'h11);
		rd(34, 8'h10);
		sel[35][1] = 1'b0;
		repeat (20) @(negedge mclk);
		reset = 1'b0;
		for (int s = 0; s < NS; s++) begin
			if (s == 41) begin
				run = 1'b0;
				repeat (40) @(negedge mclk);
				run = 1'b1;
			end
			@(posedge in_ref);
			@(negedge mclk);
			for (int n = 0; n < 16; n++) begin
				if (n == 4)
					{din, bw_n} = {dn[s], bn[s]};
				if (n == 12)
					{din, bw_n, rd_sel_n, wr_sel_n, addr} = {dk[s], bk[s], sel[s], ad[s]};
				if (n == 6 || n == 14)
					for (int v = 0; v < 3; v++) begin
						chk("enable", 36'(ee[s][n / 8]), 36'(en[v]));
						if (ee[s][n / 8]) chk("data", eq[v][s][n / 8], q[v] & lm(v, 4'h0));
					end
				if (n < 15)
					@(negedge mclk);
			end
		end
		tally_and_finish();
	end
	initial begin
		#(2000 * 25);
		failures++;
		tally_and_finish();
	end
endmodule
bind burst_write_byte_mask burst_write_byte_mask_checker #(.DATA_W(DATA_W))
	i_burst_write_byte_mask_checker (.MCLK(MCLK), .RESET(RESET),
	.INPUT_TIMING_REF(INPUT_TIMING_REF),
	.INPUT_TIMING_REF_INVERTED(INPUT_TIMING_REF_INVERTED),
	.OUTPUT_TIMING_REF(OUTPUT_TIMING_REF),
	.OUTPUT_TIMING_REF_INVERTED(OUTPUT_TIMING_REF_INVERTED),
	.READ_PORT_SELECT_N(READ_PORT_SELECT_N),
	.WRITE_PORT_SELECT_N(WRITE_PORT_SELECT_N), .DATA_OUT(DATA_OUT),
	.DATA_OUT_EN(DATA_OUT_EN));
